// [capture_channel.sv]
// Purpose: One input capture channel: synchroniser, edge detector, capture register.
// Assumes: Pin is asynchronous; counter is the registered free-running count.
// Notes: The captured value keeps its content through reset.
module capture_channel (
  input wire logic clk,
  input wire logic reset,
  capture_channel_if.channel ch
);
  import timer_capture_pkg::*;

  typedef struct packed {
    logic sync_first;
    logic sync_second;
    logic previous;
    logic pending;
    logic [15:0] value;
  } channel_s;

  channel_s state;
  channel_s next_state;
  logic rise;
  logic fall;
  logic hit;

  always_comb begin
    next_state = state;
    rise = state.sync_second && !state.previous;
    fall = !state.sync_second && state.previous;
    unique case (ch.edge_mode)
      EDGE_OFF: hit = 1'b0;
      EDGE_RISE: hit = rise;
      EDGE_FALL: hit = fall;
      EDGE_ANY: hit = rise || fall;
    endcase
    next_state.sync_first = ch.pin;
    next_state.sync_second = state.sync_first;
    next_state.previous = state.sync_second;
    if (hit) begin
      next_state.pending = 1'b1;
    end
    // A high-byte read holds the transfer off so the low byte read next stays coherent.
    if ((hit || state.pending) && !ch.hi_read) begin
      // The count is already registered, so it is stable while it is latched.
      next_state.value = ch.counter;
      next_state.pending = 1'b0;
    end else if (ch.wr_hi) begin
      next_state.value[15:8] = ch.wr_data;
    end else if (ch.wr_lo) begin
      next_state.value[7:0] = ch.wr_data;
    end
    if (reset) begin
      next_state.sync_first = 1'b0;
      next_state.sync_second = 1'b0;
      next_state.previous = 1'b0;
      next_state.pending = 1'b0;
      next_state.value = state.value;
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign ch.value = state.value;

endmodule : capture_channel

// [capture_channel_if.sv]
// Purpose: Signals between the timer core and one capture channel.
// Assumes: One clock domain.
// Notes: The core owns the controls; the channel owns the captured value.
interface capture_channel_if;
  logic [1:0] edge_mode;
  logic pin;
  logic [15:0] counter;
  logic hi_read;
  logic wr_hi;
  logic wr_lo;
  logic [7:0] wr_data;
  logic [15:0] value;

  modport core (output edge_mode, pin, counter, hi_read, wr_hi, wr_lo, wr_data, input value);
  modport channel (input edge_mode, pin, counter, hi_read, wr_hi, wr_lo, wr_data, output value);
endinterface : capture_channel_if

// [pin_event_source.sv]
// Purpose: External world on port pins: event levels, resolved with the device's drive.
// Assumes: Pins 2..0 are inputs only.
// Notes: A pin the device drives shows the device's value.
module pin_event_source (
  input wire logic [7:0] ext_level,
  input wire logic [7:3] pin_out,
  input wire logic [7:3] pin_oe_n,
  output logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    pin_in[2:0] = ext_level[2:0];
    for (int i = 3; i < 8; i++) begin
      pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
    end
  end
endmodule : pin_event_source

// [testbench.sv]
// Purpose: Self-checking bench for the timer front end.
// Assumes: Watchdog shortened to 2 taps of 16 cycles.
// Notes: Captures are compared by spacing, not absolute count.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_capture_pkg::*;
  logic clk;
  logic reset;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [7:0] reg_rdata;
  logic [7:0] pin_in;
  logic [7:3] pin_out;
  logic [7:3] pin_oe_n;
  logic [7:3] compare_level;
  logic [7:0] ext_level;
  logic reset_pin_out;
  logic reset_pin_oe_n;
  logic counter_overflow;
  int error_cnt = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [15:0] v0;
  logic [15:0] v1;
  logic [15:0] v2;
  logic [7:0] b;

  timer_input_capture_unit #(.WATCHDOG_TAP_LOG2(4), .WATCHDOG_TIMEOUT_TAPS(2))
  timer_input_capture_unit_inst (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .compare_level(compare_level), .pulse_accum_input(), .phase_two_clock(),
    .counter_overflow(counter_overflow), .reset_pin_out(reset_pin_out),
    .reset_pin_oe_n(reset_pin_oe_n)
  );
  pin_event_source pin_event_source_inst (
    .ext_level(ext_level), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ======
  // Bus and compare tasks
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd8(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd8

  // High byte then low byte on back-to-back cycles, as one double-byte access.
  task automatic rd16(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_addr <= a + 5'h01;
    #1 d[15:8] = reg_rdata;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d[7:0] = reg_rdata;
  endtask : rd16

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wait_oe(input logic lvl);
    for (int i = 0; i < 80 && reset_pin_oe_n !== lvl; i++) @(posedge clk);
    check("reset pin enable", {15'h0000, lvl}, {15'h0000, reset_pin_oe_n});
  endtask : wait_oe

  task automatic report_and_stop;
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      error_cnt++;
      $display("[FAIL] run time expected below 90000 seen %0d", cycles);
      report_and_stop();
    end
  end

  // ======
  // Scenarios
  initial begin
    reset = 1'b1;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    ext_level = 8'h00;
    compare_level = 5'h00;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd8(OFS_EDGE_CTRL, b);
    check("edge control", 16'h0000, {8'h00, b});
    rd8(OFS_PULSE_ACCUM_CTRL, b);
    check("pin3 direction", 16'h0000, {8'h00, b});
    while (counter_overflow !== 1'b1) @(posedge clk);
    rd16(OFS_COUNTER_HI, v0);
    check("count after wrap", 16'h0001, {15'h0000, v0 < 16'h0010});
    rd8(OFS_TIMER_STATUS, b);
    check("overflow flag", 16'h0001, {15'h0000, b[7]});
    wr(OFS_TIMER_STATUS, 8'h80);
    rd8(OFS_TIMER_STATUS, b);
    check("flag cleared", 16'h0000, {15'h0000, b[7]});
    for (int p = 0; p < 4; p++) begin
      wr(OFS_PULSE_ACCUM_CTRL, 8'(p));
      rd16(OFS_COUNTER_HI, v0);
      repeat (61) @(posedge clk);
      rd16(OFS_COUNTER_HI, v1);
      check("count rate", 16'(64 >> (p == 0 ? 0 : p + 1)), v1 - v0);
    end
    wr(OFS_PULSE_ACCUM_CTRL, 8'h00);
    wait_oe(1'b0);
    wait_oe(1'b1);
    for (int i = 0; i < 30; i++) begin
      wr(OFS_WATCHDOG_SERVICE, WATCHDOG_ARM_CODE);
      wr(OFS_WATCHDOG_SERVICE, WATCHDOG_CLEAR_CODE);
      check("serviced watchdog", 16'h0001, {15'h0000, reset_pin_oe_n});
    end
    wait_oe(1'b0);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_EDGE_CTRL, 8'(c << 6));
      rd16(OFS_CAPTURE_BASE, v0);
      ext_level[2] <= 1'b1;
      repeat (6) @(posedge clk);
      rd16(OFS_CAPTURE_BASE, v1);
      check("rise capture", {15'h0000, c[0]}, {15'h0000, v1 !== v0});
      ext_level[2] <= 1'b0;
      repeat (6) @(posedge clk);
      rd16(OFS_CAPTURE_BASE, v0);
      check("fall capture", {15'h0000, c[1]}, {15'h0000, v0 !== v1});
    end
    wr(OFS_EDGE_CTRL, 8'hfc);
    ext_level[2:1] <= 2'b11;
    repeat (10) @(posedge clk);
    ext_level[0] <= 1'b1;
    repeat (6) @(posedge clk);
    rd16(OFS_CAPTURE_BASE, v0);
    rd16(OFS_CAPTURE_BASE + 5'h02, v1);
    rd16(OFS_CAPTURE_BASE + 5'h04, v2);
    check("same cycle capture", v0, v1);
    check("capture spacing", 16'h000a, v2 - v0);
    ext_level[2:1] <= 2'b00;
    @(posedge clk);
    rd16(OFS_CAPTURE_BASE, v2);
    check("held during read", v0, v2);
    repeat (4) @(posedge clk);
    rd16(OFS_CAPTURE_BASE, v1);
    rd16(OFS_CAPTURE_BASE + 5'h02, v2);
    check("delayed capture", v2 + 16'h0001, v1);
    wr(OFS_EDGE_CTRL, 8'h03);
    wr(OFS_CAPTURE_BASE + 5'h06, 8'h12);
    wr(OFS_CAPTURE_BASE + 5'h07, 8'h34);
    ext_level[3] <= 1'b1;
    repeat (6) @(posedge clk);
    rd16(OFS_CAPTURE_BASE + 5'h06, v0);
    check("compare mode", 16'h1234, v0);
    wr(OFS_PULSE_ACCUM_CTRL, 8'h04);
    wr(OFS_CAPTURE_BASE + 5'h06, 8'hab);
    rd16(OFS_CAPTURE_BASE + 5'h06, v0);
    check("write discarded", 16'h1234, v0);
    ext_level[3] <= 1'b0;
    repeat (6) @(posedge clk);
    rd16(OFS_CAPTURE_BASE + 5'h06, v1);
    check("fourth capture", 16'h0001, {15'h0000, v1 !== v0});
    wr(OFS_PULSE_ACCUM_CTRL, 8'h0c);
    wr(OFS_PIN_LEVEL, 8'h08);
    repeat (6) @(posedge clk);
    rd16(OFS_CAPTURE_BASE + 5'h06, v0);
    check("driven edge", 16'h0001, {15'h0000, v0 !== v1});
    wr(OFS_PULSE_ACCUM_CTRL, 8'h00);
    ext_level[3:0] <= 4'h5;
    repeat (4) @(posedge clk);
    rd8(OFS_PIN_LEVEL, b);
    check("pin levels", 16'h0005, {12'h000, b[3:0]});
    wr(OFS_COMPARE_OWNER, 8'h40);
    compare_level[6] <= 1'b1;
    wr(OFS_PIN_LEVEL, 8'h70);
    repeat (2) @(posedge clk);
    check("owned pin", 16'h0007, {13'h0000, pin_out[6:4]});
    compare_level[6] <= 1'b0;
    wr(OFS_COMPARE_OWNER, 8'h00);
    repeat (2) @(posedge clk);
    check("ignored write", 16'h0003, {13'h0000, pin_out[6:4]});
    wr(OFS_FIRST_COMPARE_MASK, 8'h80);
    compare_level[7] <= 1'b1;
    repeat (2) @(posedge clk);
    check("first compare pin", 16'h0002, {14'h0000, pin_out[7], pin_oe_n[7]});
    rd16(OFS_CAPTURE_BASE, v0);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd16(OFS_CAPTURE_BASE, v1);
    check("kept through reset", v0, v1);
    rd8(OFS_EDGE_CTRL, b);
    check("edge control after reset", 16'h0000, {8'h00, b});
    report_and_stop();
  end
endmodule : testbench

// [timer_capture_pkg.sv]
// Purpose: Shared constants of the timer front end: register map, fields, resets, codes.
// Assumes: An 8-bit register port with a 5-bit address on a 20 MHz bus clock.
// Notes: The bus clock is the timer's E clock; one bus cycle is one clock.
package timer_capture_pkg;

  // ==========================================================================
  // Register bus
  // ==========================================================================
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_PULSE_ACCUM_CTRL = 5'h01;
  localparam logic [ADDR_W-1:0] OFS_EDGE_CTRL = 5'h02;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_OWNER = 5'h03;
  localparam logic [ADDR_W-1:0] OFS_FIRST_COMPARE_MASK = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNTER_HI = 5'h05;
  localparam logic [ADDR_W-1:0] OFS_COUNTER_LO = 5'h06;
  localparam logic [ADDR_W-1:0] OFS_TIMER_STATUS = 5'h07;
  localparam logic [ADDR_W-1:0] OFS_WATCHDOG_SERVICE = 5'h08;
  // Capture channel n: high byte at base + 2n, low byte at base + 2n + 1.
  localparam logic [ADDR_W-1:0] OFS_CAPTURE_BASE = 5'h10;
  localparam int CHANNELS = 4;

  // ==========================================================================
  // Fields
  // ==========================================================================
  localparam int PAC_PIN7_DIR_BIT = 7;
  localparam int PAC_PIN3_DIR_BIT = 3;
  localparam int PAC_C4C5_SEL_BIT = 2;
  localparam int PAC_PRESCALE_LSB = 0;
  localparam int STATUS_OVERFLOW_BIT = 7;
  localparam int SHARED_CHANNEL = 3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] PAC_RESET = 8'h00;
  localparam logic [7:0] EDGE_RESET = 8'h00;
  localparam logic [7:0] PORT_DATA_RESET = 8'h00;
  localparam logic [7:0] OWNER_RESET = 8'h00;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  // Pins 6..4 driven low, pins 7 and 3 released.
  localparam logic [4:0] PIN_OE_N_RESET = 5'h11;

  // ==========================================================================
  // Codes and timing
  // ==========================================================================
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;
  localparam logic [3:0] PRESCALE_MASK_1 = 4'h0;
  localparam logic [3:0] PRESCALE_MASK_4 = 4'h3;
  localparam logic [3:0] PRESCALE_MASK_8 = 4'h7;
  localparam logic [3:0] PRESCALE_MASK_16 = 4'hf;
  localparam logic [7:0] WATCHDOG_ARM_CODE = 8'h55;
  localparam logic [7:0] WATCHDOG_CLEAR_CODE = 8'haa;
  localparam logic [2:0] RESET_PULSE_CYCLES = 3'h4;

endpackage : timer_capture_pkg

// [timer_input_capture_unit.sv]
// Purpose: Main timer front end: prescaled counter, watchdog tap, port pin sharing, captures.
// Assumes: Register port strobes are one cycle; pins are synchronous inputs except captures.
// Notes: Compare pin levels come from the compare logic outside this block.
module timer_input_capture_unit #(
  parameter int WATCHDOG_TAP_LOG2 = 15,
  parameter int WATCHDOG_TIMEOUT_TAPS = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [timer_capture_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [timer_capture_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [timer_capture_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [7:0] pin_in,
  output logic [7:3] pin_out,
  output logic [7:3] pin_oe_n,
  input wire logic [7:3] compare_level,
  output logic pulse_accum_input,
  output logic phase_two_clock,
  output logic counter_overflow,
  output logic reset_pin_out,
  output logic reset_pin_oe_n
);
  import timer_capture_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [7:0] port_data;
    logic [7:0] pulse_accum_control;
    logic [7:0] capture_edge_control;
    logic [7:0] compare_owner;
    logic [7:0] first_compare_mask;
    logic [15:0] chain;
    logic [15:0] free_running_counter;
    logic [7:0] counter_lo_buffer;
    logic overflow;
    logic overflow_pulse;
    logic phase;
    logic watchdog_armed;
    logic [7:0] watchdog_taps;
    logic [2:0] reset_hold;
    logic reset_drive_n;
    logic [7:0] rdata;
    logic [7:3] pin_out;
    logic [7:3] pin_oe_n;
    logic accum_in;
  } timer_s;

  timer_s state;
  timer_s next_state;

  localparam logic [7:0] TIMEOUT_TAPS = 8'(WATCHDOG_TIMEOUT_TAPS);

  capture_channel_if ch_bus [CHANNELS] ();

  logic [15:0] value_of [CHANNELS];
  logic [3:0] prescale_mask;
  logic prescale_tick;
  logic watchdog_tap;
  logic [7:3] owned;
  logic capture4_compare5_select;
  logic [CHANNELS-1:0] channel_pin;
  logic [CHANNELS-1:0] hi_read;
  logic [CHANNELS-1:0] wr_hi;
  logic [CHANNELS-1:0] wr_lo;
  logic [1:0] chan_index;
  logic in_capture_space;

  // ==========================================================================
  // Capture channels
  // ==========================================================================
  assign capture4_compare5_select = state.pulse_accum_control[PAC_C4C5_SEL_BIT];
  // Channel pins: one on pin 2, two on pin 1, three on pin 0, four on pin 3.
  // With pin 3 driven as output and not compare-owned, the pad follows port writes, so they capture.
  assign channel_pin = {pin_in[3], pin_in[0], pin_in[1], pin_in[2]};

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : gen_channel
      assign ch_bus[g].edge_mode =
        (g == SHARED_CHANNEL && !capture4_compare5_select) ? EDGE_OFF
        : state.capture_edge_control[2*(CHANNELS-1-g) +: 2];
      assign ch_bus[g].pin = channel_pin[g];
      assign ch_bus[g].counter = state.free_running_counter;
      assign ch_bus[g].hi_read = hi_read[g];
      assign ch_bus[g].wr_hi = wr_hi[g];
      assign ch_bus[g].wr_lo = wr_lo[g];
      assign ch_bus[g].wr_data = reg_wdata;
      assign value_of[g] = ch_bus[g].value;
      capture_channel u_channel (
        .clk(clk),
        .reset(reset),
        .ch(ch_bus[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Register decode
  // ==========================================================================
  assign in_capture_space = (reg_addr[ADDR_W-1:3] == OFS_CAPTURE_BASE[ADDR_W-1:3]);
  assign chan_index = reg_addr[2:1];

  always_comb begin
    hi_read = '0;
    wr_hi = '0;
    wr_lo = '0;
    if (in_capture_space) begin
      hi_read[chan_index] = reg_read && !reg_addr[0];
      // Only the shared register takes writes, and only in compare mode.
      if (chan_index == 2'(SHARED_CHANNEL) && !capture4_compare5_select) begin
        wr_hi[chan_index] = reg_write && !reg_addr[0];
        wr_lo[chan_index] = reg_write && reg_addr[0];
      end
    end
  end

  // ==========================================================================
  // Prescaler and watchdog tap
  // ==========================================================================
  always_comb begin
    unique case (state.pulse_accum_control[PAC_PRESCALE_LSB +: 2])
      2'h0: prescale_mask = PRESCALE_MASK_1;
      2'h1: prescale_mask = PRESCALE_MASK_4;
      2'h2: prescale_mask = PRESCALE_MASK_8;
      2'h3: prescale_mask = PRESCALE_MASK_16;
    endcase
  end

  assign prescale_tick = ((state.chain[3:0] & prescale_mask) == prescale_mask);
  assign watchdog_tap = (state.chain[WATCHDOG_TAP_LOG2-1:0] == '1);

  // ==========================================================================
  // Pin ownership
  // ==========================================================================
  always_comb begin
    owned = state.first_compare_mask[7:3] | state.compare_owner[7:3];
    if (capture4_compare5_select) begin
      owned[3] = state.first_compare_mask[3];
    end
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_state = state;
    next_state.chain = state.chain + 16'h0001;
    next_state.phase = !state.phase;
    next_state.overflow_pulse = 1'b0;
    if (prescale_tick) begin
      next_state.free_running_counter = state.free_running_counter + 16'h0001;
      if (state.free_running_counter == 16'hffff) begin
        next_state.overflow_pulse = 1'b1;
      end
    end

    // Watchdog: time out after a run of taps with no service.
    if (state.reset_hold != 3'h0) begin
      next_state.reset_hold = state.reset_hold - 3'h1;
    end
    if (watchdog_tap) begin
      if (state.watchdog_taps == TIMEOUT_TAPS - 8'h01) begin
        next_state.watchdog_taps = 8'h00;
        next_state.reset_hold = RESET_PULSE_CYCLES;
      end else begin
        next_state.watchdog_taps = state.watchdog_taps + 8'h01;
      end
    end
    next_state.reset_drive_n = (next_state.reset_hold == 3'h0);

    // Register writes.
    if (reg_write) begin
      unique case (reg_addr)
        OFS_PIN_LEVEL: begin
          for (int b = 3; b <= 7; b++) begin
            if (!owned[b]) begin
              next_state.port_data[b] = reg_wdata[b];
            end
          end
        end
        OFS_PULSE_ACCUM_CTRL: next_state.pulse_accum_control = reg_wdata;
        OFS_EDGE_CTRL: next_state.capture_edge_control = reg_wdata;
        OFS_COMPARE_OWNER: next_state.compare_owner = {1'b0, reg_wdata[6:3], 3'h0};
        OFS_FIRST_COMPARE_MASK: next_state.first_compare_mask = {reg_wdata[7:3], 3'h0};
        OFS_TIMER_STATUS: begin
          if (reg_wdata[STATUS_OVERFLOW_BIT]) begin
            next_state.overflow = 1'b0;
          end
        end
        OFS_WATCHDOG_SERVICE: begin
          if (reg_wdata == WATCHDOG_ARM_CODE) begin
            next_state.watchdog_armed = 1'b1;
          end else if (reg_wdata == WATCHDOG_CLEAR_CODE && state.watchdog_armed) begin
            next_state.watchdog_armed = 1'b0;
            next_state.watchdog_taps = 8'h00;
          end else begin
            next_state.watchdog_armed = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // A wrap in the same cycle as a clear keeps the flag set.
    if (next_state.overflow_pulse) begin
      next_state.overflow = 1'b1;
    end

    // Register reads; unmapped addresses read zero.
    next_state.rdata = 8'h00;
    if (reg_read) begin
      if (in_capture_space) begin
        next_state.rdata = reg_addr[0] ? value_of[chan_index][7:0]
          : value_of[chan_index][15:8];
      end else begin
        unique case (reg_addr)
          OFS_PIN_LEVEL: next_state.rdata = pin_in;
          OFS_PULSE_ACCUM_CTRL: next_state.rdata = state.pulse_accum_control;
          OFS_EDGE_CTRL: next_state.rdata = state.capture_edge_control;
          OFS_COMPARE_OWNER: next_state.rdata = state.compare_owner;
          OFS_FIRST_COMPARE_MASK: next_state.rdata = state.first_compare_mask;
          OFS_COUNTER_HI: begin
            next_state.rdata = state.free_running_counter[15:8];
            next_state.counter_lo_buffer = state.free_running_counter[7:0];
          end
          OFS_COUNTER_LO: next_state.rdata = state.counter_lo_buffer;
          OFS_TIMER_STATUS: next_state.rdata = {state.overflow, 7'h00};
          default: next_state.rdata = 8'h00;
        endcase
      end
    end

    // Pin drive: compare-owned pins follow the compare logic.
    for (int b = 3; b <= 7; b++) begin
      next_state.pin_out[b] = owned[b] ? compare_level[b] : state.port_data[b];
    end
    next_state.pin_oe_n[6:4] = 3'h0;
    next_state.pin_oe_n[3] = !(state.pulse_accum_control[PAC_PIN3_DIR_BIT] || owned[3]);
    next_state.pin_oe_n[7] = !(state.pulse_accum_control[PAC_PIN7_DIR_BIT] || owned[7]);
    next_state.accum_in = pin_in[7];

    if (reset) begin
      next_state = '0;
      next_state.port_data = PORT_DATA_RESET;
      next_state.pulse_accum_control = PAC_RESET;
      next_state.capture_edge_control = EDGE_RESET;
      next_state.compare_owner = OWNER_RESET;
      next_state.first_compare_mask = OWNER_RESET;
      next_state.free_running_counter = COUNTER_RESET;
      next_state.pin_oe_n = PIN_OE_N_RESET;
      next_state.reset_drive_n = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign reg_rdata = state.rdata;
  assign pin_out = state.pin_out;
  assign pin_oe_n = state.pin_oe_n;
  assign pulse_accum_input = state.accum_in;
  assign phase_two_clock = state.phase;
  assign counter_overflow = state.overflow;
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe_n = state.reset_drive_n;

endmodule : timer_input_capture_unit

// [timer_unit_checker_props.sv]
// Purpose: Port checker for the timer front end.
// Assumes: One clock domain; reset synchronous and active high.
// Notes: Sees only the top module's ports.
module timer_unit_checker
#(
  parameter int WATCHDOG_TAP_LOG2 = 15,
  parameter int WATCHDOG_TIMEOUT_TAPS = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [timer_capture_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [timer_capture_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [7:0] pin_in,
  input wire logic pulse_accum_input,
  input wire logic phase_two_clock,
  input wire logic counter_overflow,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n
);
  import timer_capture_pkg::*;
  logic [7:0] pin_d1;
  logic [7:0] pin_d2;
  logic [7:0] pin_d3;
  always_ff @(posedge clk) begin
    pin_d1 <= pin_in;
    pin_d2 <= pin_d1;
    pin_d3 <= pin_d2;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ======
  // Assertions
  a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_live_level: assert property ($past(reg_read) && $past(reg_addr) == OFS_PIN_LEVEL
    && pin_d1 == pin_d2 && pin_d2 == pin_d3 |-> reg_rdata[3:0] == pin_d1[3:0])
    else $error("pin read differs from pin levels");
  a_phase_toggle: assert property (!$past(reset) |-> phase_two_clock != $past(phase_two_clock))
    else $error("phase clock did not toggle");
  a_accum_copy: assert property (!$past(reset) |-> pulse_accum_input == pin_d1[7])
    else $error("accumulator input does not follow pin seven");
  a_reset_drive: assert property (reset_pin_out == 1'b0)
    else $error("reset pin value not low");
  a_pulse_width: assert property ($fell(reset_pin_oe_n) |->
    !reset_pin_oe_n [*4] ##1 reset_pin_oe_n)
    else $error("reset pulse length wrong");
  a_flag_sticky: assert property (!$past(reset) && $past(counter_overflow)
    && !($past(reg_write) && $past(reg_addr) == OFS_TIMER_STATUS) |-> counter_overflow)
    else $error("overflow flag lost");
  a_status_read: assert property ($past(reg_read) && $past(reg_addr) == OFS_TIMER_STATUS
    |-> reg_rdata[7] == $past(counter_overflow))
    else $error("status read differs from overflow flag");
  c_wd_pulse: cover property ($fell(reset_pin_oe_n));
  c_overflow: cover property ($rose(counter_overflow));
  c_cap_read: cover property (reg_read && reg_addr == OFS_CAPTURE_BASE);
endmodule : timer_unit_checker

bind timer_input_capture_unit timer_unit_checker #(
  .WATCHDOG_TAP_LOG2(WATCHDOG_TAP_LOG2),
  .WATCHDOG_TIMEOUT_TAPS(WATCHDOG_TIMEOUT_TAPS)
) timer_unit_checker_inst (
  .clk(clk),
  .reset(reset),
  .reg_addr(reg_addr),
  .reg_write(reg_write),
  .reg_read(reg_read),
  .reg_rdata(reg_rdata),
  .pin_in(pin_in),
  .pulse_accum_input(pulse_accum_input),
  .phase_two_clock(phase_two_clock),
  .counter_overflow(counter_overflow),
  .reset_pin_out(reset_pin_out),
  .reset_pin_oe_n(reset_pin_oe_n)
);
